// >>> src/ldw_write_port.sv
// Contract
// - Data lines are captured at the rising edge of the write strobe.
// - Select high loads the control word, select low loads display RAM.
// - RAM write: lines 0..7 are data bits 1..8, top bit is decimal point.
// - Control line 6 high picks hexadecimal font, low picks the Code B font.
// - Control line 5 high gives raw segments, low gives font decoding.
// - Control line 7 high: burst data follows; low: single-digit addressing.
// - Control line 4 low shuts down: scan stops and all outputs dark.
// - With burst low, lines 0..2 are the digit address, line 0 the LSB.
// - Control line 3 picks bank A when high, B when low, decoded modes only.
// - Eight digit outputs, each active only during its own digit.
// - Segment outputs a..g plus point carry the pattern of the driven digit.
// - The host writes a control word before any display RAM data.
// - Decoded modes store four bits per digit per bank; raw stores eight.
// - Decimal point storage is shared by both banks.
`timescale 1ns/1ps
module ldw_write_port
  import ldw_pkg::*;
#(
  parameter int DIGIT_CYCLES = LDW_DIGIT_CYCLES,
  parameter int BLANK_CYCLES = LDW_BLANK_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] in_line,
  input wire logic dest_select,
  input wire logic write_strobe,
  output logic [7:0] digit_drive,
  output logic [6:0] segment_out,
  output logic point_segment_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] in_sync1_reg, in_sync2_reg;
  logic sel_sync1_reg, sel_sync2_reg;
  logic wr_sync1_reg, wr_sync2_reg, wr_sync3_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_sync1_reg <= '0;
      in_sync2_reg <= '0;
      sel_sync1_reg <= 1'b0;
      sel_sync2_reg <= 1'b0;
      wr_sync1_reg <= 1'b0;
      wr_sync2_reg <= 1'b0;
      wr_sync3_reg <= 1'b0;
    end else begin
      in_sync1_reg <= in_line;
      in_sync2_reg <= in_sync1_reg;
      sel_sync1_reg <= dest_select;
      sel_sync2_reg <= sel_sync1_reg;
      wr_sync1_reg <= write_strobe;
      wr_sync2_reg <= wr_sync1_reg;
      wr_sync3_reg <= wr_sync2_reg;
    end
  end

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  ldw_ctrl_type ctrl_reg;
  ldw_wstate_type wstate_reg, wstate_next;
  logic [2:0] ptr_reg, ptr_next;
  wire ldw_ctrl_type ctrl_in = ldw_ctrl_type'(in_sync2_reg);
  wire logic wr_rise = wr_sync2_reg & ~wr_sync3_reg;
  wire logic ctrl_wr = wr_rise & sel_sync2_reg;
  wire logic ram_wr = wr_rise & ~sel_sync2_reg;
  wire logic ram_accept = ram_wr & (wstate_reg != LDW_IDLE);
  wire logic burst_done = (wstate_reg == LDW_BURST) && (ptr_reg == LDW_LAST_DIGIT);

  always_comb begin
    wstate_next = wstate_reg;
    ptr_next = ptr_reg;
    if (ctrl_wr) begin
      wstate_next = ctrl_in.burst ? LDW_BURST : LDW_SINGLE;
      ptr_next = ctrl_in.burst ? LDW_FIRST_DIGIT : ctrl_in.addr;
    end else if (ram_accept) begin
      unique case (wstate_reg)
        LDW_BURST: begin
          ptr_next = ptr_reg + 3'h1;
          wstate_next = burst_done ? LDW_IDLE : LDW_BURST;
        end
        LDW_SINGLE: ptr_next = ptr_reg;
        default: wstate_next = LDW_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= ldw_ctrl_type'(LDW_CTRL_RESET);
      wstate_reg <= LDW_IDLE;
      ptr_reg <= LDW_FIRST_DIGIT;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= ctrl_in;
      end
      wstate_reg <= wstate_next;
      ptr_reg <= ptr_next;
    end
  end

  // ---------------------------------------------------------------
  // Display storage
  // ---------------------------------------------------------------
  logic [LDW_NIBBLE_W-1:0] bank_a_mem [LDW_DIGITS];
  logic [LDW_NIBBLE_W-1:0] bank_b_mem [LDW_DIGITS];
  logic [7:0] raw_mem [LDW_DIGITS];
  logic [LDW_DIGITS-1:0] point_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LDW_DIGITS; i++) begin
        bank_a_mem[i] <= '0;
        bank_b_mem[i] <= '0;
        raw_mem[i] <= '0;
      end
      point_reg <= '0;
    end else if (ram_accept) begin
      if (ctrl_reg.raw) begin
        raw_mem[ptr_reg] <= in_sync2_reg;
      end else begin
        if (ctrl_reg.bank_a) begin
          bank_a_mem[ptr_reg] <= in_sync2_reg[LDW_NIBBLE_W-1:0];
        end else begin
          bank_b_mem[ptr_reg] <= in_sync2_reg[LDW_NIBBLE_W-1:0];
        end
        point_reg[ptr_reg] <= in_sync2_reg[LDW_POINT_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Font decoder, segments ordered g down to a
  // ---------------------------------------------------------------
  function automatic logic [6:0] font_seg(input logic [3:0] val, input logic hex);
    logic [6:0] s;
    s = LDW_SEG_DARK;
    unique case (val)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      4'ha: s = hex ? 7'h77 : 7'h40;
      4'hb: s = hex ? 7'h7c : 7'h79;
      4'hc: s = hex ? 7'h39 : 7'h76;
      4'hd: s = hex ? 7'h5e : 7'h38;
      4'he: s = hex ? 7'h79 : 7'h73;
      4'hf: s = hex ? 7'h71 : 7'h00;
    endcase
    return s;
  endfunction

  // ---------------------------------------------------------------
  // Multiplex scan
  // ---------------------------------------------------------------
  logic [LDW_TICK_W-1:0] tick_reg;
  logic [2:0] scan_reg;
  ldw_drive_type drive_reg;
  wire logic tick_end = (tick_reg == LDW_TICK_W'(DIGIT_CYCLES - 1));
  wire logic in_gap = (tick_reg < LDW_TICK_W'(BLANK_CYCLES));
  wire logic [3:0] nibble = ctrl_reg.bank_a ? bank_a_mem[scan_reg] : bank_b_mem[scan_reg];
  wire logic [6:0] seg_pick = ctrl_reg.raw ? raw_mem[scan_reg][LDW_SEG_W-1:0]
                                           : font_seg(nibble, ctrl_reg.font_hex);
  wire logic point_pick = ctrl_reg.raw ? raw_mem[scan_reg][LDW_POINT_BIT] : point_reg[scan_reg];
  wire logic lit = ctrl_reg.run & ~in_gap;
  wire ldw_drive_type drive_next = lit
      ? '{digit: LDW_DIGIT_ONE << scan_reg, seg: seg_pick, point: point_pick}
      : '{digit: LDW_DIGIT_DARK, seg: LDW_SEG_DARK, point: 1'b0};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= '0;
      scan_reg <= LDW_FIRST_DIGIT;
      drive_reg <= '0;
    end else begin
      if (!ctrl_reg.run) begin
        tick_reg <= '0;
        scan_reg <= LDW_FIRST_DIGIT;
      end else if (tick_end) begin
        tick_reg <= '0;
        scan_reg <= scan_reg + 3'h1;
      end else begin
        tick_reg <= tick_reg + LDW_TICK_W'(1);
      end
      drive_reg <= drive_next;
    end
  end

  assign digit_drive = drive_reg.digit;
  assign segment_out = drive_reg.seg;
  assign point_segment_out = drive_reg.point;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_ctrl_load_edge: assert property (ctrl_wr |=> ctrl_reg == $past(in_sync2_reg))
    else $error("control word not loaded at write edge");
  a_ram_keeps_ctrl: assert property (ram_wr && !ctrl_wr |=> $stable(ctrl_reg))
    else $error("RAM write changed control word");
  a_burst_starts: assert property (ctrl_wr && ctrl_in.burst |=>
      wstate_reg == LDW_BURST && ptr_reg == LDW_FIRST_DIGIT)
    else $error("burst did not start at digit one");
  a_single_address: assert property (ctrl_wr && !ctrl_in.burst |=>
      wstate_reg == LDW_SINGLE && ptr_reg == $past(in_sync2_reg[2:0]))
    else $error("single digit address wrong");
  a_burst_ends: assert property (ram_accept && burst_done |=> wstate_reg == LDW_IDLE)
    else $error("burst did not end after eight writes");
  a_point_shared: assert property (ram_accept && !ctrl_reg.raw |=>
      point_reg[$past(ptr_reg)] == $past(in_sync2_reg[LDW_POINT_BIT]))
    else $error("decimal point not stored");
  a_nibble_bank_a: assert property (ram_accept && !ctrl_reg.raw && ctrl_reg.bank_a |=>
      bank_a_mem[$past(ptr_reg)] == $past(in_sync2_reg[3:0]))
    else $error("bank A nibble not stored");
  a_raw_word: assert property (ram_accept && ctrl_reg.raw |=>
      raw_mem[$past(ptr_reg)] == $past(in_sync2_reg))
    else $error("raw word not stored");
  a_digit_onehot: assert property ($onehot0(digit_drive))
    else $error("more than one digit driven");
  a_digit_gap: assert property (digit_drive != LDW_DIGIT_DARK &&
      $past(digit_drive) != LDW_DIGIT_DARK |-> $stable(digit_drive))
    else $error("digits overlap without gap");
  a_shutdown_dark: assert property (!ctrl_reg.run |=>
      digit_drive == LDW_DIGIT_DARK && segment_out == LDW_SEG_DARK && !point_segment_out)
    else $error("outputs lit in shutdown");
  a_seg_follows: assert property (lit && !ctrl_reg.raw |=>
      segment_out == $past(font_seg(nibble, ctrl_reg.font_hex)))
    else $error("decoded segments wrong");

  c_burst_full: cover property (ram_accept && burst_done);
  c_single_write: cover property (ram_accept && wstate_reg == LDW_SINGLE);
  c_shutdown: cover property (ctrl_wr && !ctrl_in.run);
  c_raw_lit: cover property (lit && ctrl_reg.raw);

endmodule

// >>> src/ldw_pkg.sv
package ldw_pkg;

  // ---------------------------------------------------------------
  // Geometry and field layout
  // ---------------------------------------------------------------
  localparam int LDW_DIGITS = 8;
  localparam int LDW_ADDR_W = 3;
  localparam int LDW_NIBBLE_W = 4;
  localparam int LDW_SEG_W = 7;
  localparam int LDW_POINT_BIT = 7;
  localparam logic [2:0] LDW_LAST_DIGIT = 3'h7;
  localparam logic [2:0] LDW_FIRST_DIGIT = 3'h0;

  // ---------------------------------------------------------------
  // Scan timing
  // ---------------------------------------------------------------
  localparam int LDW_CLK_MHZ = 40;
  localparam int LDW_DIGIT_TIME_US = 25;
  localparam int LDW_BLANK_TIME_NS = 1000;
  localparam int LDW_DIGIT_CYCLES = LDW_DIGIT_TIME_US * LDW_CLK_MHZ;
  localparam int LDW_BLANK_CYCLES = (LDW_BLANK_TIME_NS * LDW_CLK_MHZ + 999) / 1000;
  localparam int LDW_TICK_W = 16;

  // ---------------------------------------------------------------
  // Control word, bit 7 down to bit 0 as seen at the data lines
  // ---------------------------------------------------------------
  typedef struct packed {
    logic burst;
    logic font_hex;
    logic raw;
    logic run;
    logic bank_a;
    logic [2:0] addr;
  } ldw_ctrl_type;

  localparam logic [7:0] LDW_CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] digit;
    logic [6:0] seg;
    logic point;
  } ldw_drive_type;

  localparam logic [6:0] LDW_SEG_DARK = 7'h00;
  localparam logic [7:0] LDW_DIGIT_DARK = 8'h00;
  localparam logic [7:0] LDW_DIGIT_ONE = 8'h01;

  typedef enum logic [1:0] {
    LDW_IDLE = 2'b00,
    LDW_BURST = 2'b01,
    LDW_SINGLE = 2'b11
  } ldw_wstate_type;

endpackage

// >>> sim/ldw_host_model.sv
`timescale 1ns/1ps
module ldw_host_model (
  input wire logic core_clk,
  output logic [7:0] in_line,
  output logic dest_select,
  output logic write_strobe
);
  initial begin
    in_line = 8'h5a;
    dest_select = 1'b0;
    write_strobe = 1'b0;
  end

  // Data and select settle four cycles before the strobe rises and stay put until
  // four cycles after it falls, then the lines show a changed value.
  task automatic write_word(input logic sel, input logic [7:0] data);
    @(posedge core_clk) #1;
    in_line = data;
    dest_select = sel;
    repeat (4) @(posedge core_clk);
    #1 write_strobe = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 write_strobe = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 in_line = ~data;
    dest_select = ~sel;
  endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ldw_pkg::*;
  localparam int DIG = 20;
  localparam int BLK = 4;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] in_line;
  logic dest_select;
  logic write_strobe;
  logic [7:0] digit_drive;
  logic [6:0] segment_out;
  logic point_segment_out;
  int n_fail = 0;
  int samples_checked = 0;
  logic [7:0] exp_pat [8];
  logic [3:0] nibs [2][8];
  logic pts [8];
  logic [7:0] ctrl_tab [3] = '{8'h58, 8'h50, 8'h18};
  logic [2:0] addr;
  logic [7:0] b;

  always #12.5 core_clk = ~core_clk;

  ldw_host_model host_u (.core_clk(core_clk), .in_line(in_line),
    .dest_select(dest_select), .write_strobe(write_strobe));
  ldw_write_port #(.DIGIT_CYCLES(DIG), .BLANK_CYCLES(BLK)) dut_u (.core_clk(core_clk),
    .arst_n(arst_n), .in_line(in_line), .dest_select(dest_select),
    .write_strobe(write_strobe), .digit_drive(digit_drive), .segment_out(segment_out),
    .point_segment_out(point_segment_out));

  // ----
  // Checking
  // ----
  function automatic logic [6:0] font_seg(input logic hex, input logic [3:0] nib);
    case (nib)
      4'h0: return 7'h3f;
      4'h1: return 7'h06;
      4'h2: return 7'h5b;
      4'h3: return 7'h4f;
      4'h4: return 7'h66;
      4'h5: return 7'h6d;
      4'h6: return 7'h7d;
      4'h7: return 7'h07;
      4'h8: return 7'h7f;
      4'h9: return 7'h6f;
      4'ha: return hex ? 7'h77 : 7'h40;
      4'hb: return hex ? 7'h7c : 7'h79;
      4'hc: return hex ? 7'h39 : 7'h76;
      4'hd: return hex ? 7'h5e : 7'h38;
      4'he: return hex ? 7'h79 : 7'h73;
      default: return hex ? 7'h71 : 7'h00;
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic scan_check(input logic dark);
    logic [7:0] seen;
    int idx;
    int lit_n;
    seen = 8'h00;
    idx = 0;
    lit_n = 0;
    repeat (2 * DIG) @(posedge core_clk);
    repeat (2 * 8 * DIG) begin
      @(negedge core_clk);
      if (dark) begin
        chk("dark outputs", 16'h0, {digit_drive, segment_out, point_segment_out});
      end else if (digit_drive !== 8'h00) begin
        for (int i = 0; i < 8; i++) if (digit_drive[i]) idx = i;
        chk("digit_drive", 16'(8'h01 << idx), 16'(digit_drive));
        chk("pattern", 16'(exp_pat[idx]), 16'({point_segment_out, segment_out}));
        seen[idx] = 1'b1;
        lit_n++;
      end else begin
        chk("gap dark", 16'h0, 16'({segment_out, point_segment_out}));
      end
    end
    if (!dark) chk("digits seen", 16'hff, 16'(seen));
    if (!dark) chk("lit cycles", 16'(2 * 8 * (DIG - BLK)), 16'(lit_n));
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    complete_run();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'hf002));
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1'b1;
    scan_check(1'b1);
    host_u.write_word(1'b1, 8'hb0);
    for (int i = 0; i < 8; i++) begin
      exp_pat[i] = 8'($urandom());
      host_u.write_word(1'b0, exp_pat[i]);
    end
    host_u.write_word(1'b0, ~exp_pat[0]);
    scan_check(1'b0);
    for (int k = 0; k < 4; k++) begin
      addr = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom());
      host_u.write_word(1'b1, {5'b00110, addr});
      b = 8'($urandom());
      host_u.write_word(1'b0, b);
      exp_pat[addr] = b;
      scan_check(1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      host_u.write_word(1'b1, (k == 0) ? 8'hd8 : 8'hd0);
      for (int i = 0; i < 8; i++) begin
        nibs[k][i] = 4'($urandom());
        pts[i] = 1'($urandom());
        host_u.write_word(1'b0, {pts[i], 3'($urandom()), nibs[k][i]});
      end
    end
    for (int m = 0; m < 3; m++) begin
      host_u.write_word(1'b1, ctrl_tab[m]);
      b = 8'($urandom());
      host_u.write_word(1'b0, b);
      nibs[ctrl_tab[m][3] ? 0 : 1][0] = b[3:0];
      pts[0] = b[7];
      for (int i = 0; i < 8; i++) begin
        exp_pat[i] = {pts[i], font_seg(ctrl_tab[m][6], nibs[ctrl_tab[m][3] ? 0 : 1][i])};
      end
      scan_check(1'b0);
    end
    host_u.write_word(1'b1, 8'h00);
    scan_check(1'b1);
    complete_run();
  end
endmodule
